//--- hw/ata_wr_pkg.sv
// Constants, types and register map of the write-class command engine
// Functional notes
// - Command 87h completes at once with no media action.
// - That no-op completion leaves zero in the sector count register.
// - Command E8h takes 512 bytes into the buffer with PIO sequencing.
// - Command CAh writes 1 to 256 sectors by DMA; count 0 means 256.
// - Start address is head, cylinder high, cylinder low, sector number.
// - DMA write sets busy on acceptance, then requests DMA while able.
// - DMA write interrupts only at completion or on error.
// - DMA success leaves the last written sector in the address registers.
// - DMA error stops at the failing sector and reports its address.
// - DMA write is aborted when 8-bit transfer mode is enabled.
// - Command C5h shows busy within 400 ns of acceptance.
// - Block writes set data request at block starts and interrupt at later block starts and at completion.
// - Count is in sectors; full blocks first, then a partial block.
// - Block write aborts without a valid block size or when disabled.
// - Block write error ends at the failing sector, no later blocks.
// - Block write error loads failing address and residual count.
// - Only block size 1 is supported and reported as the limit.
// - Command CDh is the block write without implicit erase.
// - PIO write clears busy, sets data request and interrupts per sector.
// - Rejected or zero block size keeps block transfers disabled.
package ata_wr_pkg;

    // Command codes
    localparam logic [7:0] CMD_TRANSLATE = 8'h87;
    localparam logic [7:0] CMD_WR_BUFFER = 8'hE8;
    localparam logic [7:0] CMD_WR_DMA = 8'hCA;
    localparam logic [7:0] CMD_WR_MULT = 8'hC5;
    localparam logic [7:0] CMD_WR_MULT_NE = 8'hCD;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_DRIVE_HEAD = 8'h04;
    localparam logic [7:0] OFS_CYL_HIGH = 8'h08;
    localparam logic [7:0] OFS_CYL_LOW = 8'h0C;
    localparam logic [7:0] OFS_SECT_NUM = 8'h10;
    localparam logic [7:0] OFS_SECT_CNT = 8'h14;
    localparam logic [7:0] OFS_FEATURE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_ERROR = 8'h20;
    localparam logic [7:0] OFS_DATA = 8'h24;
    localparam logic [7:0] OFS_CONFIG = 8'h28;

    // Field positions
    localparam int ST_BSY_BIT = 7;
    localparam int ST_DRDY_BIT = 6;
    localparam int ST_DRQ_BIT = 3;
    localparam int ST_ERR_BIT = 0;
    localparam int ERR_WFAULT_BIT = 6;
    localparam int ERR_ABRT_BIT = 2;
    localparam int CFG_8BIT_BIT = 0;
    localparam int CFG_MULT_EN_BIT = 1;
    localparam int CFG_BLK_LSB = 8;
    localparam int CFG_MAXBLK_LSB = 16;
    localparam int SYNC_DMACK = 0;
    localparam int SYNC_IOWR = 1;
    localparam int SYNC_MERR = 2;

    // Reset values and fixed figures
    localparam logic [7:0] TF_RESET = 8'h00;
    localparam logic [7:0] BLK_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h3;
    localparam logic [7:0] MAX_BLOCK_COUNT = 8'h01;
    localparam logic [7:0] WORD_LAST = 8'hFF;
    localparam logic [8:0] SECTORS_AT_ZERO = 9'h100;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int BUSY_MAX_NS = 400;
    localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS = 2000;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ACCEPT = 3'b001,
        S_PIO = 3'b010,
        S_DMA = 3'b011,
        S_PROG = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        M_BUF = 2'b00,
        M_DMA = 2'b01,
        M_MULT = 2'b10,
        M_NONE = 2'b11
    } mode_t;

    typedef struct packed {
        logic [7:0] drive_head_select;
        logic [7:0] cylinder_high_address;
        logic [7:0] cylinder_low_address;
        logic [7:0] sector_number_address;
        logic [7:0] sector_count_value;
        logic [7:0] feature_select;
    } taskfile_t;

    typedef struct packed {
        logic active;
        logic no_erase;
        logic [27:0] lba;
    } media_cmd_t;

endpackage

//--- hw/ata_write_command_engine.sv
// Write-class ATA command engine with APB task file and DMA pins
`timescale 1ns/1ns
`default_nettype none
module ata_write_command_engine
    import ata_wr_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dmack_n,
    input wire logic iowr_n,
    input wire logic [15:0] dd_in,
    input wire logic media_err,
    output logic dmarq,
    output logic intrq,
    output var media_cmd_t media,
    input wire logic [7:0] buf_rd_addr,
    output logic [15:0] buf_rd_data
);

    typedef struct packed {
        state_t st;
        mode_t mode;
        logic [7:0] cmd;
        taskfile_t tf;
        logic cfg_8bit;
        logic cfg_mult_en;
        logic [7:0] cfg_blk;
        logic err_abrt;
        logic err_wfault;
        logic st_err;
        logic intrq;
        logic dmarq;
        logic [27:0] lba;
        logic [8:0] rem;
        logic [7:0] blk_left;
        logic [7:0] widx;
        logic [15:0] prog_cnt;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        media_cmd_t media;
    } eng_t;

    eng_t r;
    eng_t next_r;
    logic [15:0] sector_buf [256];
    logic buf_we;
    logic [7:0] buf_waddr;
    logic [15:0] buf_wdata;
    logic take;
    logic word_in;
    logic busy;
    logic drq;
    logic mult_ok;

    // Sector count 0 stands for 256 sectors
    function automatic logic [8:0] sector_total(input logic [7:0] sc);
        sector_total = (sc == 8'h00) ? SECTORS_AT_ZERO : {1'b0, sc};
    endfunction

    // Address decode for the mapped registers
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == OFS_COMMAND) || (a == OFS_DRIVE_HEAD) ||
            (a == OFS_CYL_HIGH) || (a == OFS_CYL_LOW) ||
            (a == OFS_SECT_NUM) || (a == OFS_SECT_CNT) ||
            (a == OFS_FEATURE) || (a == OFS_STATUS) ||
            (a == OFS_ERROR) || (a == OFS_DATA) || (a == OFS_CONFIG);
    endfunction

    // Task file address fields to a 28-bit sector address
    function automatic logic [27:0] tf_lba(input taskfile_t t);
        tf_lba = {t.drive_head_select[3:0], t.cylinder_high_address,
            t.cylinder_low_address, t.sector_number_address};
    endfunction

    // Status view derived from the engine state
    assign busy = (r.st == S_ACCEPT) || (r.st == S_PROG);
    assign drq = (r.st == S_PIO) || (r.st == S_DMA);
    assign take = psel && penable && r.pready;
    assign mult_ok = r.cfg_mult_en && (r.cfg_blk != 8'h00) &&
        (r.cfg_blk <= MAX_BLOCK_COUNT);

    // Next-state logic for bus, pins and command sequencing
    always_comb begin
        next_r = r;
        buf_we = 1'b0;
        buf_waddr = r.widx;
        buf_wdata = 16'h0000;
        word_in = 1'b0;

        // Pin synchronisers; a level changes once stages two and three agree
        next_r.s1 = {media_err, iowr_n, dmack_n};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));

        // APB answer one cycle into the access phase
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = psel && penable && !r.pready && !reg_mapped(paddr);
        if (psel && penable && !r.pready && !pwrite) begin
            unique case (paddr)
                OFS_DRIVE_HEAD: next_r.prdata =
                    {24'h0, r.tf.drive_head_select};
                OFS_CYL_HIGH: next_r.prdata =
                    {24'h0, r.tf.cylinder_high_address};
                OFS_CYL_LOW: next_r.prdata =
                    {24'h0, r.tf.cylinder_low_address};
                OFS_SECT_NUM: next_r.prdata =
                    {24'h0, r.tf.sector_number_address};
                OFS_SECT_CNT: next_r.prdata = {24'h0, r.tf.sector_count_value};
                OFS_STATUS: begin
                    next_r.prdata = 32'h0;
                    next_r.prdata[ST_BSY_BIT] = busy;
                    next_r.prdata[ST_DRDY_BIT] = 1'b1;
                    next_r.prdata[ST_DRQ_BIT] = drq;
                    next_r.prdata[ST_ERR_BIT] = r.st_err;
                end
                OFS_ERROR: begin
                    next_r.prdata = 32'h0;
                    next_r.prdata[ERR_WFAULT_BIT] = r.err_wfault;
                    next_r.prdata[ERR_ABRT_BIT] = r.err_abrt;
                end
                OFS_CONFIG: begin
                    next_r.prdata = 32'h0;
                    next_r.prdata[CFG_8BIT_BIT] = r.cfg_8bit;
                    next_r.prdata[CFG_MULT_EN_BIT] = r.cfg_mult_en;
                    next_r.prdata[CFG_BLK_LSB +: 8] = r.cfg_blk;
                    next_r.prdata[CFG_MAXBLK_LSB +: 8] =
                        MAX_BLOCK_COUNT;
                end
                default: next_r.prdata = 32'h0;
            endcase
        end

        // Register writes and the status read side effect
        if (take && !pwrite && paddr == OFS_STATUS) begin
            next_r.intrq = 1'b0;
        end
        if (take && pwrite && r.st == S_IDLE) begin
            unique case (paddr)
                OFS_DRIVE_HEAD: next_r.tf.drive_head_select = pwdata[7:0];
                OFS_CYL_HIGH: next_r.tf.cylinder_high_address = pwdata[7:0];
                OFS_CYL_LOW: next_r.tf.cylinder_low_address = pwdata[7:0];
                OFS_SECT_NUM: next_r.tf.sector_number_address = pwdata[7:0];
                OFS_SECT_CNT: next_r.tf.sector_count_value = pwdata[7:0];
                OFS_FEATURE: next_r.tf.feature_select = pwdata[7:0];
                OFS_CONFIG: begin
                    next_r.cfg_8bit = pwdata[CFG_8BIT_BIT];
                    next_r.cfg_mult_en = pwdata[CFG_MULT_EN_BIT];
                    next_r.cfg_blk = pwdata[CFG_BLK_LSB +: 8];
                end
                OFS_COMMAND: begin
                    next_r.cmd = pwdata[7:0];
                    next_r.st = S_ACCEPT;
                    next_r.intrq = 1'b0;
                    next_r.st_err = 1'b0;
                    next_r.err_abrt = 1'b0;
                    next_r.err_wfault = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Data words: PIO through the data register, DMA through the pins
        if (r.st == S_PIO && take && pwrite && paddr == OFS_DATA) begin
            word_in = 1'b1;
            buf_wdata = pwdata[15:0];
        end
        if (r.st == S_DMA && r.lvl[SYNC_IOWR] && !next_r.lvl[SYNC_IOWR] &&
            !r.lvl[SYNC_DMACK]) begin
            word_in = 1'b1;
            buf_wdata = dd_in;
        end
        if (word_in) begin
            buf_we = 1'b1;
            next_r.widx = r.widx + 8'h01;
            if (r.widx == WORD_LAST) begin
                next_r.st = S_PROG;
                next_r.prog_cnt = (r.mode == M_BUF) ? 16'h0001 :
                    PROG_CYCLES[15:0];
                next_r.media.active = (r.mode != M_BUF);
                next_r.media.lba = r.lba;
            end
        end

        // Command dispatch and sector sequencing
        unique case (r.st)
            S_IDLE: begin
            end
            S_ACCEPT: begin
                next_r.lba = tf_lba(r.tf);
                next_r.rem = sector_total(r.tf.sector_count_value);
                next_r.widx = 8'h00;
                next_r.blk_left = r.cfg_blk;
                next_r.media.no_erase = (r.cmd == CMD_WR_MULT_NE);
                if (r.cmd == CMD_TRANSLATE) begin
                    next_r.tf.sector_count_value = 8'h00;
                    next_r.mode = M_NONE;
                    next_r.intrq = 1'b1;
                    next_r.st = S_IDLE;
                end else if (r.cmd == CMD_WR_BUFFER) begin
                    next_r.mode = M_BUF;
                    next_r.st = S_PIO;
                end else if (r.cmd == CMD_WR_DMA && !r.cfg_8bit) begin
                    next_r.mode = M_DMA;
                    next_r.st = S_DMA;
                end else if ((r.cmd == CMD_WR_MULT ||
                    r.cmd == CMD_WR_MULT_NE) && mult_ok) begin
                    next_r.mode = M_MULT;
                    next_r.st = S_PIO;
                end else begin
                    next_r.mode = M_NONE;
                    next_r.err_abrt = 1'b1;
                    next_r.st_err = 1'b1;
                    next_r.intrq = 1'b1;
                    next_r.st = S_IDLE;
                end
            end
            S_PIO: begin
            end
            S_DMA: begin
            end
            S_PROG: begin
                if (r.prog_cnt != 16'h0001) begin
                    next_r.prog_cnt = r.prog_cnt - 16'h0001;
                end else begin
                    next_r.media.active = 1'b0;
                    next_r.widx = 8'h00;
                    if (r.mode != M_BUF && r.lvl[SYNC_MERR]) begin
                        // Stop at the failing sector, no later blocks
                        next_r.tf.drive_head_select[3:0] = r.lba[27:24];
                        next_r.tf.cylinder_high_address = r.lba[23:16];
                        next_r.tf.cylinder_low_address = r.lba[15:8];
                        next_r.tf.sector_number_address = r.lba[7:0];
                        if (r.mode == M_MULT) begin
                            next_r.tf.sector_count_value = r.rem[7:0];
                        end
                        next_r.err_wfault = 1'b1;
                        next_r.st_err = 1'b1;
                        next_r.intrq = 1'b1;
                        next_r.st = S_IDLE;
                    end else if (r.mode == M_BUF || r.rem == 9'h001) begin
                        if (r.mode != M_BUF) begin
                            next_r.tf.drive_head_select[3:0] = r.lba[27:24];
                            next_r.tf.cylinder_high_address = r.lba[23:16];
                            next_r.tf.cylinder_low_address = r.lba[15:8];
                            next_r.tf.sector_number_address =
                                r.lba[7:0];
                            next_r.tf.sector_count_value = 8'h00;
                        end
                        next_r.intrq = 1'b1;
                        next_r.st = S_IDLE;
                    end else begin
                        next_r.rem = r.rem - 9'h001;
                        next_r.lba = r.lba + 28'h0000001;
                        if (r.mode == M_DMA) begin
                            next_r.st = S_DMA;
                        end else begin
                            next_r.st = S_PIO;
                            if (r.blk_left == 8'h01) begin
                                next_r.blk_left = r.cfg_blk;
                                next_r.intrq = 1'b1;
                            end else begin
                                next_r.blk_left = r.blk_left - 8'h01;
                            end
                        end
                    end
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase

        // DMA request stands while the engine can take words
        next_r.dmarq = (next_r.st == S_DMA);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= S_IDLE;
            r.mode <= M_NONE;
            r.tf <= {6{TF_RESET}};
            r.cfg_blk <= BLK_RESET;
            r.s1 <= SYNC_RESET;
            r.s2 <= SYNC_RESET;
            r.s3 <= SYNC_RESET;
            r.lvl <= SYNC_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Sector buffer write port
    always_ff @(posedge pclk) begin
        if (buf_we) begin
            sector_buf[buf_waddr] <= buf_wdata;
        end
    end

    // Registered read port toward the media back end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_rd_data <= 16'h0000;
        end else begin
            buf_rd_data <= sector_buf[buf_rd_addr];
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign dmarq = r.dmarq;
    assign intrq = r.intrq;
    assign media = r.media;

    // Command acceptance in idle
    sequence cmd_taken_s;
        take && pwrite && paddr == OFS_COMMAND && r.st == S_IDLE;
    endsequence

    sequence busy_then_dispatch_s;
        busy ##1 !(r.st == S_ACCEPT);
    endsequence

    busy_on_cmd_a: assert property (@(posedge pclk)
        disable iff (!presetn) cmd_taken_s |=> busy_then_dispatch_s)
        else $error("busy not shown right after command");

    translate_zero_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmd_taken_s and (pwdata[7:0] == CMD_TRANSLATE) |-> ##2
        (r.tf.sector_count_value == 8'h00 && r.intrq && r.st == S_IDLE))
        else $error("translate did not return zero count");

    abort_8bit_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmd_taken_s and (pwdata[7:0] == CMD_WR_DMA) and r.cfg_8bit |-> ##2
        (r.err_abrt && r.st_err && r.intrq && !busy))
        else $error("8-bit DMA write not aborted");

    abort_mult_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmd_taken_s and (pwdata[7:0] == CMD_WR_MULT) and !mult_ok |-> ##2
        (r.err_abrt && r.intrq && r.st == S_IDLE))
        else $error("block write without block size not aborted");

    dma_request_a: assert property (@(posedge pclk)
        disable iff (!presetn) (r.st == S_DMA) |-> r.dmarq && !busy)
        else $error("DMA request missing while taking data");

    dma_no_int_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        $rose(r.intrq) |-> !($past(r.mode) == M_DMA && r.st == S_DMA))
        else $error("interrupt raised between DMA sectors");

    residual_count_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (r.st == S_PROG && r.prog_cnt == 16'h0001 && r.mode == M_MULT &&
        r.lvl[SYNC_MERR]) |=> (r.tf.sector_count_value == $past(r.rem[7:0]) &&
        tf_lba(r.tf) == $past(r.lba) && r.st_err))
        else $error("block write error report wrong");

    last_addr_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (r.st == S_PROG && r.prog_cnt == 16'h0001 && r.mode == M_DMA &&
        !r.lvl[SYNC_MERR] && r.rem == 9'h001) |=>
        (tf_lba(r.tf) == $past(r.lba) && r.intrq && !r.st_err))
        else $error("last sector address not left after DMA write");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !r.pready) |=> r.pready ##1 !r.pready)
        else $error("APB answer not one cycle");

endmodule
`default_nettype wire

//--- tb/ata_host_model.sv
// Host-side DMA model: acknowledges and strobes words while requested
`timescale 1ns/1ns
`default_nettype none
module ata_host_model (
    input wire logic pclk,
    input wire logic dmarq,
    output logic dmack_n,
    output logic iowr_n,
    output logic [15:0] dd_in
);
    logic [15:0] w;
    // One strobe per word; data held past the strobe's rising edge
    initial begin
        dmack_n = 1'b1;
        iowr_n = 1'b1;
        dd_in = 16'hFFFF;
        w = 16'h0000;
        forever begin
            @(posedge pclk);
            if (dmarq) begin
                dmack_n <= 1'b0;
                // Acknowledge must pass the sync before the strobe does
                repeat (3) @(posedge pclk);
                dd_in <= w;
                iowr_n <= 1'b0;
                repeat (6) @(posedge pclk);
                iowr_n <= 1'b1;
                repeat (2) @(posedge pclk);
                dd_in <= ~w; // Released bus shows no stale word
                w <= w + 16'h0001;
                repeat (4) @(posedge pclk);
            end else begin
                dmack_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/ata_write_command_engine_tb_top.sv
// Bench for the write command engine: APB tasks, DMA host, checks
`timescale 1ns/1ns
`default_nettype none
module ata_write_command_engine_tb_top;
    import ata_wr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, pi;
    logic dmack_n, iowr_n, media_err, dmarq, intrq, last_ne;
    logic [7:0] paddr, buf_rd_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] dd_in, buf_rd_data;
    logic [27:0] last_lba;
    media_cmd_t media;
    int n_errors, check_count, rises, rise_base;

    ata_write_command_engine #(.PROG_CYCLES(3)) ata_write_command_engine_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dmack_n(dmack_n),
        .iowr_n(iowr_n), .dd_in(dd_in), .media_err(media_err),
        .dmarq(dmarq), .intrq(intrq), .media(media),
        .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data));
    ata_host_model ata_host_model_i (.pclk(pclk), .dmarq(dmarq),
        .dmack_n(dmack_n), .iowr_n(iowr_n), .dd_in(dd_in));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Interrupt edges and the sector being programmed
    always @(posedge pclk) begin
        if (intrq && !pi) rises++;
        pi <= intrq;
        if (media.active) begin
            last_lba <= media.lba;
            last_ne <= media.no_erase;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("BAD t=%0t no pready", $time);
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll status until not busy (and no data request unless allowed)
    task automatic st_wait(input logic drq_ok);
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while ((rd[ST_BSY_BIT] !== 1'b0 || (!drq_ok &&
                  rd[ST_DRQ_BIT] !== 1'b0)) && k < 4000);
        if (k >= 4000) begin
            n_errors++;
            $display("BAD t=%0t status wait timed out", $time);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] n,
                       input logic [27:0] a);
        apb(1'b1, OFS_DRIVE_HEAD, {24'h0, 4'hE, a[27:24]});
        apb(1'b1, OFS_CYL_HIGH, {24'h0, a[23:16]});
        apb(1'b1, OFS_CYL_LOW, {24'h0, a[15:8]});
        apb(1'b1, OFS_SECT_NUM, {24'h0, a[7:0]});
        apb(1'b1, OFS_SECT_CNT, {24'h0, n});
        rise_base = rises;
        apb(1'b1, OFS_COMMAND, {24'h0, c});
    endtask
    // One sector of PIO data, word i carries value i
    task automatic sector;
        for (int i = 0; i < 256; i++) apb(1'b1, OFS_DATA, 32'(i));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #(40 * 60000);
        n_errors++;
        final_report;
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, media_err} = 5'h0;
        {paddr, pwdata, buf_rd_addr} = 48'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(OFS_CONFIG, 32'h0001_0000);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, se}, 32'h1);
        cmd(CMD_TRANSLATE, 8'h05, 28'h0);
        st_wait(1'b0);
        chk(rd, 32'h40);
        rdc(OFS_SECT_CNT, 32'h0);
        cmd(8'hFF, 8'h01, 28'h0);
        st_wait(1'b0);
        chk(rd, 32'h41);
        cmd(CMD_WR_MULT, 8'h01, 28'h0);
        st_wait(1'b0);
        chk(rd, 32'h41);
        rdc(OFS_ERROR, 32'h4);
        apb(1'b1, OFS_CONFIG, 32'h1);
        cmd(CMD_WR_DMA, 8'h01, 28'h0);
        st_wait(1'b0);
        chk(rd, 32'h41);
        apb(1'b1, OFS_CONFIG, 32'h0102);
        cmd(CMD_WR_MULT, 8'h02, 28'h1234567);
        st_wait(1'b1);
        chk(rd, 32'h48);
        sector();
        st_wait(1'b1);
        chk(rd, 32'h48);
        sector();
        st_wait(1'b0);
        chk(rises - rise_base, 2);
        chk(last_lba, 28'h1234568);
        rdc(OFS_SECT_NUM, 32'h68);
        media_err <= 1'b1;
        // Sectors 10h to 12h were never written, so they stand erased
        cmd(CMD_WR_MULT_NE, 8'h03, 28'h0000010);
        st_wait(1'b1);
        sector();
        st_wait(1'b0);
        chk(rd, 32'h41);
        chk(last_ne, 1'b1);
        rdc(OFS_SECT_CNT, 32'h3);
        rdc(OFS_SECT_NUM, 32'h10);
        rdc(OFS_ERROR, 32'h40);
        media_err <= 1'b0;
        cmd(CMD_WR_DMA, 8'h02, 28'h0ABCDEF);
        st_wait(1'b0);
        chk(rises - rise_base, 1);
        chk(last_lba, 28'h0ABCDF0);
        rdc(OFS_SECT_NUM, 32'hF0);
        // Second DMA sector carries host words 100h onward
        buf_rd_addr <= 8'h05;
        repeat (2) @(posedge pclk);
        chk(buf_rd_data, 16'h0105);
        cmd(CMD_WR_BUFFER, 8'h00, 28'h0);
        st_wait(1'b1);
        sector();
        st_wait(1'b0);
        buf_rd_addr <= 8'h05;
        repeat (2) @(posedge pclk);
        chk(buf_rd_data, 16'h0005);
        final_report;
    end
endmodule
`default_nettype wire
